// ### xbi_pkg.sv
// shared constants and carrier types for the external memory bus interface
package xbi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle timing, one oscillator period per core_clk
    localparam int unsigned MC_LEN      = 12;   // oscillator periods per machine cycle
    localparam logic [3:0]  PH_FIRST    = 4'h0; // first phase, address goes out
    localparam logic [3:0]  PH_ALE_A    = 4'h0; // first latch strobe pulse start
    localparam logic [3:0]  PH_ALE_B    = 4'h6; // second latch strobe pulse start
    localparam logic [3:0]  ALE_WIDTH   = 4'h2; // latch strobe pulse width
    localparam logic [3:0]  PH_ADDR_END = 4'h2; // last phase with address on low port
    localparam logic [3:0]  PH_STB_ON   = 4'h3; // read strobes fall
    localparam logic [3:0]  PH_WR_ON    = 4'h4; // write strobe falls
    localparam logic [3:0]  PH_STB_OFF  = 4'hA; // last phase with strobes low
    localparam logic [3:0]  PH_LAST     = 4'hB; // final phase of a machine cycle

    // reset pin must stay high this long before it takes effect
    localparam int unsigned RESET_MC    = 2;
    localparam logic [4:0]  RESET_CLKS  = 5'(RESET_MC * MC_LEN);

    // on-chip code region and address space
    localparam int unsigned ADDR_W      = 16;   // 64K program and 64K data spaces
    localparam logic [15:0] ONCHIP_TOP  = 16'h2000; // 8K bytes of on-chip code

    ////////////////////////////////////////////////////////////////////////////
    // request kinds from the core
    typedef enum logic [1:0] {
        KIND_FETCH,   // instruction fetch
        KIND_CREAD,   // code_table_read_instr access
        KIND_XREAD,   // external data read
        KIND_XWRITE   // external data write
    } xbi_kind_t;

    // operation held for one machine cycle
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_INTERNAL,
        OP_FETCH,
        OP_CREAD,
        OP_XREAD,
        OP_XWRITE
    } xbi_op_t;

    // request from the core
    typedef struct packed {
        xbi_kind_t        kind;
        logic [15:0]      addr;
        logic [7:0]       wdata;
    } xbi_req_t;

    // answer to the core
    typedef struct packed {
        logic             valid;    // one-cycle pulse
        logic             internal; // core must use on-chip code memory
        logic [7:0]       rdata;    // byte read from the bus
    } xbi_rsp_t;

    // pin drive, strobes active low
    typedef struct packed {
        logic             ale;
        logic             program_store_strobe_n;
        logic             rd_n;
        logic             wr_n;
        logic [7:0]       p0_out;
        logic             p0_oe;
        logic [7:0]       p2_out;
        logic             p2_oe;
    } xbi_pins_t;

    localparam xbi_pins_t PINS_IDLE = '{
        ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        p0_out: 8'h00, p0_oe: 1'b0, p2_out: 8'h00, p2_oe: 1'b0};

endpackage : xbi_pkg

// ### xbi_ext_bus.sv
// external program and data memory bus engine of the microcontroller
// Contract
// - select low: every fetch goes external
// - internal code region: nothing on bus
// - program strobe for fetch and table reads
// - no program strobe for internal code
// - latch strobe separates low address, data
// - low port multiplexes address then data
// - upper address byte on second port
// - write strobe pulses for data writes
// - read strobe pulses for data reads
// - separate 64K program and data spaces
// - reset pin high two cycles resets
// - off bit suppresses latch strobe toggling
// - latch strobe returns for external accesses
module xbi_ext_bus (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // device pins, inputs
    input  wire logic                reset_pin,
    input  wire logic                external_access_select,
    input  wire logic [7:0]          p0_in,
    // core side control
    input  wire logic                latch_strobe_off_bit,
    input  wire logic                req_valid,
    input  xbi_pkg::xbi_req_t        req,
    output logic                     req_ready,
    output xbi_pkg::xbi_rsp_t        rsp,
    output logic                     in_reset,
    // device pins, outputs
    output xbi_pkg::xbi_pins_t       pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import xbi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchronisers
    logic       ea_s1_r;        // first stage, read only by second
    logic       ea_s2_r;        // synchronised access select
    logic       rpin_s1_r;      // first stage of reset pin
    logic       rpin_s2_r;      // synchronised reset pin
    logic [7:0] p0_s1_r;        // first stage of low port
    logic [7:0] p0_s2_r;        // synchronised low port

    // two flops on every pin before any logic looks at it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ea_s1_r   <= 1'b0;
            ea_s2_r   <= 1'b0;
            rpin_s1_r <= 1'b0;
            rpin_s2_r <= 1'b0;
            p0_s1_r   <= 8'h00;
            p0_s2_r   <= 8'h00;
        end else begin
            ea_s1_r   <= external_access_select;
            ea_s2_r   <= ea_s1_r;
            rpin_s1_r <= reset_pin;
            rpin_s2_r <= rpin_s1_r;
            p0_s1_r   <= p0_in;
            p0_s2_r   <= p0_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing state: phase, held operation, reset filter
    logic [3:0]  phase_r;       // position inside the machine cycle
    logic [3:0]  phase_nxt;
    xbi_op_t     op_r;          // operation of the current machine cycle
    xbi_op_t     op_nxt;
    logic [15:0] addr_r;        // address of the current operation
    logic [15:0] addr_nxt;
    logic [7:0]  wdata_r;       // byte to write
    logic [7:0]  wdata_nxt;
    logic [4:0]  rst_cnt_r;     // clocks the reset pin has been high
    logic [4:0]  rst_cnt_nxt;
    logic        hold_r;        // device held in reset by the pin
    logic        hold_nxt;
    logic        ready_r;       // request slot open this cycle
    logic        ready_nxt;
    logic        accept;        // request taken at end of machine cycle
    logic        code_kind;     // request addresses program space

    // classify, accept and step the machine cycle
    always_comb begin
        phase_nxt   = phase_r;
        op_nxt      = op_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        rst_cnt_nxt = rst_cnt_r;
        hold_nxt    = hold_r;
        accept      = req_valid && ready_r && (phase_r == PH_LAST);
        code_kind   = (req.kind == KIND_FETCH) || (req.kind == KIND_CREAD);

        // short pulses on the pin are filtered out
        if (!rpin_s2_r) begin
            rst_cnt_nxt = 5'h00;
            hold_nxt    = 1'b0;
        end else if (rst_cnt_r != RESET_CLKS) begin
            rst_cnt_nxt = rst_cnt_r + 5'h01;
        end else begin
            hold_nxt    = 1'b1;
        end

        if (hold_nxt) begin
            // reset state ends any bus activity at once
            phase_nxt = PH_FIRST;
            op_nxt    = OP_IDLE;
        end else if (phase_r == PH_LAST) begin
            phase_nxt = PH_FIRST;
            op_nxt    = OP_IDLE;
            if (accept) begin
                addr_nxt  = req.addr;
                wdata_nxt = req.wdata;
                if (code_kind && ea_s2_r && (req.addr < ONCHIP_TOP)) begin
                    // on-chip code, bus stays quiet
                    op_nxt = OP_INTERNAL;
                end else begin
                    // program and data spaces kept apart by kind
                    case (req.kind)
                        KIND_FETCH:  op_nxt = OP_FETCH;
                        KIND_CREAD:  op_nxt = OP_CREAD;
                        KIND_XREAD:  op_nxt = OP_XREAD;
                        KIND_XWRITE: op_nxt = OP_XWRITE;
                        default:     op_nxt = OP_IDLE;
                    endcase
                end
            end
        end else begin
            phase_nxt = phase_r + 4'h1;
        end

        // slot opens in the last phase only
        ready_nxt = !hold_nxt && (phase_nxt == PH_LAST);
    end

    // register the sequencing state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r   <= PH_FIRST;
            op_r      <= OP_IDLE;
            addr_r    <= 16'h0000;
            wdata_r   <= 8'h00;
            rst_cnt_r <= 5'h00;
            hold_r    <= 1'b0;
            ready_r   <= 1'b0;
        end else begin
            phase_r   <= phase_nxt;
            op_r      <= op_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            hold_r    <= hold_nxt;
            ready_r   <= ready_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive, computed from the next phase so pins line up with phase_r
    xbi_pins_t pins_r;          // registered pin drive
    xbi_pins_t pins_nxt;
    logic      ext_op;          // next cycle uses the external bus
    logic      code_op;         // next cycle reads program space
    logic      in_ale_a;        // next phase inside first latch pulse
    logic      in_ale_b;        // next phase inside second latch pulse
    logic      in_strobe;       // next phase inside read strobe window
    logic      in_wr;           // next phase inside write strobe window

    always_comb begin
        pins_nxt  = PINS_IDLE;
        ext_op    = (op_nxt == OP_FETCH) || (op_nxt == OP_CREAD) ||
                    (op_nxt == OP_XREAD) || (op_nxt == OP_XWRITE);
        code_op   = (op_nxt == OP_FETCH) || (op_nxt == OP_CREAD);
        in_ale_a  = (phase_nxt >= PH_ALE_A) && (phase_nxt < PH_ALE_A + ALE_WIDTH);
        in_ale_b  = (phase_nxt >= PH_ALE_B) && (phase_nxt < PH_ALE_B + ALE_WIDTH);
        in_strobe = (phase_nxt >= PH_STB_ON) && (phase_nxt <= PH_STB_OFF);
        in_wr     = (phase_nxt >= PH_WR_ON) && (phase_nxt <= PH_STB_OFF);

        if (hold_nxt) begin
            // everything released while the pin holds reset
            pins_nxt = PINS_IDLE;
        end else if (ext_op) begin
            // latch strobe returns even with the off bit set; second pulse
            // withheld, it would catch the data phase in the latch
            // next address, so phase 0 of a freshly taken op already
            // shows the new address and not the previous one
            pins_nxt.ale    = in_ale_a;
            pins_nxt.p2_out = addr_nxt[15:8];
            pins_nxt.p2_oe  = 1'b1;
            if (phase_nxt <= PH_ADDR_END) begin
                pins_nxt.p0_out = addr_nxt[7:0];
                pins_nxt.p0_oe  = 1'b1;
            end else if (op_nxt == OP_XWRITE) begin
                pins_nxt.p0_out = wdata_nxt;
                pins_nxt.p0_oe  = 1'b1;
            end
            pins_nxt.program_store_strobe_n = !(code_op && in_strobe);
            pins_nxt.rd_n   = !((op_nxt == OP_XREAD) && in_strobe);
            pins_nxt.wr_n   = !((op_nxt == OP_XWRITE) && in_wr);
        end else begin
            // idle or on-chip cycle: no program strobe, bus quiet
            pins_nxt.program_store_strobe_n = 1'b1;
            pins_nxt.ale    = !latch_strobe_off_bit &&
                              (in_ale_a || in_ale_b);
        end
    end

    // register the pins, so every pin comes from a flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_r <= PINS_IDLE;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer to the core at the end of each busy machine cycle
    xbi_rsp_t rsp_r;            // registered answer
    xbi_rsp_t rsp_nxt;
    logic     done;             // last phase of an accepted operation

    // low port is sampled in the last phase; the synchroniser shows the
    // pin two phases earlier, still inside the strobe window
    always_comb begin
        rsp_nxt  = '0;
        done     = (phase_r == PH_LAST) && (op_r != OP_IDLE) && !hold_nxt;
        if (done) begin
            rsp_nxt.valid    = 1'b1;
            rsp_nxt.internal = (op_r == OP_INTERNAL);
            if ((op_r == OP_FETCH) || (op_r == OP_CREAD) ||
                (op_r == OP_XREAD)) begin
                rsp_nxt.rdata = p0_s2_r;
            end
        end
    end

    // register the answer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign req_ready = ready_r;
    assign rsp       = rsp_r;
    assign in_reset  = hold_r;
    assign pins      = pins_r;

endmodule // xbi_ext_bus

// ### xbi_ext_bus_properties.sv
// checker for the external memory bus interface
module xbi_ext_bus_chk (
    // clock and reset
    input wire logic          core_clk,
    input wire logic          rst_n,
    // pins and core side
    input wire logic          reset_pin,
    input wire logic          external_access_select,
    input wire logic [7:0]    p0_in,
    input wire logic          latch_strobe_off_bit,
    input wire logic          req_valid,
    input xbi_pkg::xbi_req_t  req,
    input wire logic          req_ready,
    input xbi_pkg::xbi_rsp_t  rsp,
    input wire logic          in_reset,
    input xbi_pkg::xbi_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import xbi_pkg::*;
    ////////////////////////////////////////
    logic        take, code_ext, ext_take, alo, ahi, wdrv, quiet; // decoded request and pin states
    logic [15:0] addr_r, addr_nxt; // address of the op in flight
    logic [7:0]  wd_r, wd_nxt;     // write byte of the op in flight
    logic [5:0]  hi_r, hi_nxt;     // reset pin high run, saturating
    assign take = req_valid && req_ready;
    assign code_ext = (req.kind == KIND_FETCH || req.kind == KIND_CREAD)
        && (!external_access_select || req.addr >= ONCHIP_TOP);
    assign ext_take = take && (code_ext || req.kind == KIND_XREAD || req.kind == KIND_XWRITE);
    assign alo = pins.p0_oe && pins.p0_out == addr_r[7:0];
    assign ahi = pins.p2_oe && pins.p2_out == addr_r[15:8];
    assign wdrv = pins.p0_oe && pins.p0_out == wd_r;
    assign quiet = pins.program_store_strobe_n && pins.rd_n && pins.wr_n && !pins.p0_oe && !pins.p2_oe;
    // capture request fields, since the core may change them after the take
    always_comb begin
        addr_nxt = take ? req.addr : addr_r;
        wd_nxt = take ? req.wdata : wd_r;
        hi_nxt = !reset_pin ? 6'h00 : hi_r + 6'(hi_r != 6'h3F);
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 16'h0000;
            wd_r <= 8'h00;
            hi_r <= 6'h00;
        end else begin
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            hi_r <= hi_nxt;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || in_reset);
    code_strobe_a: assert property (take && code_ext |=>
        (pins.program_store_strobe_n && pins.rd_n)[*3] ##1 (!pins.program_store_strobe_n && pins.rd_n)[*8] ##1 pins.program_store_strobe_n)
        else $error("program strobe timing wrong");
    int_quiet_a: assert property (take && !code_ext && !req.kind[1] |=>
        quiet[*6] ##1 quiet[*6] ##1 (rsp.valid && rsp.internal && rsp.rdata == 8'h00))
        else $error("bus activity during on-chip code access");
    addr_phase_a: assert property (ext_take |=> (pins.ale && alo && ahi)[*2] ##1
        (!pins.ale && alo && ahi) ##1 (!pins.ale && ahi)[*8] ##1 !pins.ale)
        else $error("address phase wrong");
    write_data_a: assert property (take && req.kind == KIND_XWRITE |=> ##3
        (wdrv && pins.wr_n) ##1 (wdrv && !pins.wr_n && pins.rd_n)[*7] ##1 pins.wr_n)
        else $error("write strobe or data wrong");
    read_strobe_a: assert property (take && req.kind == KIND_XREAD |=> ##3
        (!pins.rd_n && pins.program_store_strobe_n && !pins.p0_oe)[*8] ##1 pins.rd_n)
        else $error("read strobe wrong");
    ale_twice_a: assert property (req_ready && !ext_take && !latch_strobe_off_bit |=>
        pins.ale[*2] ##1 (!pins.ale)[*4] ##1 pins.ale[*2] ##1 !pins.ale)
        else $error("latch strobe rhythm wrong");
    ale_off_a: assert property (req_ready && !ext_take && latch_strobe_off_bit |=>
        (!pins.ale)[*6] ##1 (!pins.ale)[*6])
        else $error("latch strobe toggles while off");
    rsp_time_a: assert property (take |-> ##13 rsp.valid)
        else $error("answer late or missing");
    pin_filter_a: assert property (disable iff (!rst_n) $rose(in_reset) |-> hi_r >= 6'h18)
        else $error("reset taken too early");
    pin_reset_a: assert property (disable iff (!rst_n) hi_r >= 6'h1E |-> in_reset)
        else $error("reset not taken");
    reset_idle_a: assert property (disable iff (!rst_n)
        in_reset |-> pins == PINS_IDLE && !req_ready && !rsp.valid)
        else $error("bus active in reset");
    cover property (take && code_ext);
    cover property (take && req.kind == KIND_XWRITE);
    cover property (disable iff (!rst_n) $rose(in_reset));
endmodule // xbi_ext_bus_chk
bind xbi_ext_bus xbi_ext_bus_chk chk (.core_clk(core_clk), .rst_n(rst_n), .reset_pin(reset_pin),
    .external_access_select(external_access_select), .p0_in(p0_in),
    .latch_strobe_off_bit(latch_strobe_off_bit), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .in_reset(in_reset), .pins(pins));

// ### xbi_mem_model.sv
// external code and data memory with address latch
module xbi_mem_model (
    // clock
    input wire logic          core_clk,
    // device pins and answer delay
    input xbi_pkg::xbi_pins_t pins,
    input wire logic [2:0]    delay,
    output logic [7:0]        p0_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import xbi_pkg::*;
    logic [7:0]  cmem [0:65535]; // code space
    logic [7:0]  dmem [0:65535]; // data space, apart from code
    logic [7:0]  lo_r;           // latched low address
    logic [2:0]  wait_r;         // strobe cycles before data shows
    logic [15:0] addr;
    assign addr = {pins.p2_out, lo_r};
    always @(posedge core_clk) begin
        if (pins.ale) lo_r <= pins.p0_out;
        if (!pins.wr_n) dmem[addr] <= pins.p0_out;
        wait_r <= (pins.program_store_strobe_n && pins.rd_n) ? 3'h0 : wait_r + 3'(wait_r != delay);
    end
    // a released port floats up to the pull-up level
    always_comb begin
        if (pins.p0_oe) p0_in = pins.p0_out;
        else if (!pins.program_store_strobe_n && wait_r == delay) p0_in = cmem[addr];
        else if (!pins.rd_n && wait_r == delay) p0_in = dmem[addr];
        else p0_in = 8'hFF;
    end
endmodule // xbi_mem_model

// ### test_external_memory_bus_interface.sv
// self-checking bench for the external memory bus interface
module test_external_memory_bus_interface;
    timeunit 1ns;
    timeprecision 1ps;
    import xbi_pkg::*;
    logic       core_clk, rst_n, reset_pin, external_access_select;
    logic       latch_strobe_off_bit, req_valid, req_ready, in_reset;
    logic [7:0] p0_in;
    logic [2:0] delay;
    xbi_req_t   req;
    xbi_rsp_t   rsp;
    xbi_pins_t  pins;
    int         n_errors, tests_run, ale_cnt, last_ale, cyc;
    xbi_ext_bus dut (.core_clk(core_clk), .rst_n(rst_n), .reset_pin(reset_pin),
        .external_access_select(external_access_select), .p0_in(p0_in),
        .latch_strobe_off_bit(latch_strobe_off_bit), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp(rsp), .in_reset(in_reset), .pins(pins));
    xbi_mem_model mem (.core_clk(core_clk), .pins(pins), .delay(delay), .p0_in(p0_in));
    ////////////////////////////////////////
    always #2 core_clk = ~core_clk;
    // latch strobe counter and hang guard
    always @(posedge core_clk) begin
        ale_cnt <= ale_cnt + int'(pins.ale);
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_sim();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one request, answer judged in the cycle it stands
    task do_op(input xbi_kind_t k, input logic [15:0] a, input logic [7:0] w,
               input logic intl, input logic [7:0] exp);
        int n;
        int c0;
        req = '{kind: k, addr: a, wdata: w};
        req_valid = 1'b1;
        n = 0;
        // ready is looked at mid-cycle, where it has settled
        while (req_ready !== 1'b1 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        c0 = ale_cnt;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        last_ale = ale_cnt - c0;
        check(rsp.valid, 1'b1);
        check(rsp.internal, intl);
        if (k != KIND_XWRITE) check(rsp.rdata, exp);
    endtask
    task t_code;
        delay = 3'h4; // slow memory
        mem.cmem[16'h0100] = 8'hA5;
        mem.cmem[16'hFFFF] = 8'h5E;
        mem.cmem[16'h2000] = 8'hC3;
        do_op(KIND_FETCH, 16'h0100, 8'h00, 1'b0, 8'hA5);
        do_op(KIND_CREAD, 16'hFFFF, 8'h00, 1'b0, 8'h5E);
        external_access_select = 1'b1;
        repeat (4) @(negedge core_clk);
        do_op(KIND_FETCH, 16'h1FFF, 8'h00, 1'b1, 8'h00);
        do_op(KIND_CREAD, 16'h0000, 8'h00, 1'b1, 8'h00);
        do_op(KIND_FETCH, 16'h2000, 8'h00, 1'b0, 8'hC3);
    endtask
    task t_data;
        delay = 3'h0;
        mem.cmem[16'h1234] = 8'h77;
        do_op(KIND_XWRITE, 16'h1234, 8'h3C, 1'b0, 8'h00);
        check(mem.dmem[16'h1234], 8'h3C);
        do_op(KIND_XREAD, 16'h1234, 8'h00, 1'b0, 8'h3C);
        external_access_select = 1'b0;
        repeat (4) @(negedge core_clk);
        do_op(KIND_CREAD, 16'h1234, 8'h00, 1'b0, 8'h77);
    endtask
    // off bit only moves late in a machine cycle
    task t_ale;
        int c;
        mem.dmem[16'hBEEF] = 8'h96;
        do_op(KIND_XREAD, 16'hBEEF, 8'h00, 1'b0, 8'h96);
        check(last_ale, 2);
        repeat (9) @(negedge core_clk);
        latch_strobe_off_bit = 1'b1;
        repeat (15) @(negedge core_clk);
        c = ale_cnt;
        repeat (24) @(negedge core_clk);
        check(ale_cnt - c, 0);
        do_op(KIND_XREAD, 16'hBEEF, 8'h00, 1'b0, 8'h96);
        check(last_ale, 2);
        repeat (9) @(negedge core_clk);
        latch_strobe_off_bit = 1'b0;
        repeat (3) @(negedge core_clk);
        c = ale_cnt;
        repeat (24) @(negedge core_clk);
        check(ale_cnt - c, 8);
    endtask
    // short pulse ignored, two machine cycles and margin taken
    task t_pin;
        reset_pin = 1'b1;
        repeat (20) @(negedge core_clk);
        check(in_reset, 1'b0);
        reset_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        reset_pin = 1'b1;
        repeat (30) @(negedge core_clk);
        check(in_reset, 1'b1);
        check(pins, PINS_IDLE);
        reset_pin = 1'b0;
        repeat (7) @(negedge core_clk);
        check(in_reset, 1'b0);
        mem.cmem[16'h4321] = 8'h1E;
        do_op(KIND_FETCH, 16'h4321, 8'h00, 1'b0, 8'h1E);
    endtask
    initial begin
        {core_clk, rst_n, reset_pin, external_access_select} = 4'h0;
        {latch_strobe_off_bit, req_valid} = 2'h0;
        req = '0;
        delay = 3'h0;
        {n_errors, tests_run, ale_cnt, cyc} = '0;
        repeat (20) @(negedge core_clk);
        check(pins, PINS_IDLE);
        check(req_ready, 1'b0);
        rst_n = 1'b1;
        t_code();
        t_data();
        t_ale();
        t_pin();
        end_sim();
    end
endmodule // test_external_memory_bus_interface
